// ==== hw/rtc_block.v ====
// clock register block: counter with trim, deferred load, interval interrupt, watchdog
`timescale 1ns/1ps
`default_nettype none
`include "rtc_regs.vh"

module rtc_block #(
	parameter HALF_SEC_TICKS = `RTC_HALF_SEC_MS * `RTC_TB_HZ / 1000
) (
	input wire MCLK,
	input wire RST_N,
	input wire CE,
	input wire OSC32K,
	input wire XTAL_EN,
	input wire [15:0] SFR_ADDR,
	input wire [7:0] SFR_WDATA,
	input wire SFR_WR,
	input wire SFR_RD,
	output reg [7:0] SFR_RDATA,
	input wire LINK_EVENT,
	input wire KEYS_EVENT,
	output reg INT5_REQ,
	output reg WDT_RESET,
	output reg POWERDOWN_MUX_CTRL_CTRL
);

	// number of half-second marks per step is 2**n; hit when low n bits wrap
	function period_hit;
		input [3:0] marks;
		input [2:0] n;
		begin
			case (n)
			3'd0: period_hit = 1'b1;
			3'd1: period_hit = (marks[0] == 1'b0);
			3'd2: period_hit = (marks[1:0] == 2'b00);
			3'd3: period_hit = (marks[2:0] == 3'b000);
			default: period_hit = (marks == 4'h0);
			endcase
		end
	endfunction

	// one decoder for the interrupt-register strobes and the control-register write strobe
	function addr_is;
		input [15:0] addr;
		input [15:0] target;
		input strobe;
		begin
			addr_is = strobe && (addr == target);
		end
	endfunction

	// reset image of the interrupt control register, taken bit by bit
	localparam [7:0] INT5_RST = `RTC_INT5_RESET;

	wire tick;
	wire half_mark;

	reg [7:0] ctl_q;
	reg clk_ien_q;
	reg clk_flag_q;
	reg link_ien_q;
	reg link_flag_q;
	reg keys_ien_q;
	reg keys_flag_q;
	reg [31:0] cnt_wr_q;
	reg [23:0] acc_wr_q;
	reg [23:0] trim_wr_q;
	reg [31:0] cnt_q;
	reg [23:0] acc_q;
	reg [23:0] trim_q;
	reg [3:0] marks_q;
	reg [15:0] wd_q;

	reg [2:0] per_n;
	reg [2:0] int_n;
	reg [7:0] rd_mux;
	reg [31:0] cnt_d;
	reg [23:0] acc_d;

	wire [3:0] marks_d;
	wire count_step;
	wire int_step;
	wire [24:0] acc_sum;
	wire wr_int5;
	wire wr_ctl;
	wire rd_int5;
	wire do_load;
	wire wd_expire;

	rtc_timebase #(
		.HALF_SEC_TICKS(HALF_SEC_TICKS),
		.MAIN_DIV(`RTC_MAIN_DIV)
	) u_tb (
		.mclk(MCLK),
		.rst_n(RST_N),
		.ce(CE),
		.osc32k(OSC32K),
		.xtal_en(XTAL_EN),
		.tick(tick),
		.half_mark(half_mark)
	);

	assign wr_int5 = addr_is(SFR_ADDR, `RTC_INT5_ADDR, SFR_WR);
	assign wr_ctl = addr_is(SFR_ADDR, `RTC_CTL_ADDR, SFR_WR);
	// the read strobe alone clears the clock flag, whatever is returned
	assign rd_int5 = addr_is(SFR_ADDR, `RTC_INT5_ADDR, SFR_RD);
	// a load on the tick of a count step replaces that step
	assign do_load = tick && ctl_q[`RTC_CTL_LOAD];

	always @* begin
		case (ctl_q[`RTC_CTL_PER_HI:`RTC_CTL_PER_LO])
		2'b10: per_n = 3'd0;
		2'b11: per_n = 3'd2;
		default: per_n = 3'd1;
		endcase
		case (ctl_q[`RTC_CTL_INT_HI:`RTC_CTL_INT_LO])
		3'b100: int_n = 3'd0;
		3'b101: int_n = 3'd2;
		3'b110: int_n = 3'd3;
		3'b111: int_n = 3'd4;
		default: int_n = 3'd1;
		endcase
	end

	assign marks_d = marks_q + 4'h1;
	assign count_step = half_mark && period_hit(marks_d, per_n);
	assign int_step = half_mark && period_hit(marks_d, int_n);

	// magnitude only goes into the accumulator; bit 24 is the overflow
	assign acc_sum = {1'b0, acc_q} + {2'b00, trim_q[22:0]};

	always @* begin
		acc_d = acc_q;
		cnt_d = cnt_q;
		if (count_step) begin
			acc_d = acc_sum[23:0];
			// a carry adds a step for a positive trim; a negative trim eats it
			if (!acc_sum[24]) begin
				cnt_d = cnt_q + 32'h0000_0001;
			end else if (!trim_q[`RTC_TRIM_SIGN]) begin
				cnt_d = cnt_q + 32'h0000_0002;
			end
		end
	end

	// reads show the live bytes with no snapshot: a step between two byte
	// reads can tear a multi-byte value, so software reads it twice
	always @* begin
		case (SFR_ADDR)
		`RTC_INT5_ADDR: rd_mux = {POWERDOWN_MUX_CTRL_CTRL, 1'b0, clk_ien_q, clk_flag_q,
			link_ien_q, link_flag_q, keys_ien_q, keys_flag_q};
		`RTC_CTL_ADDR: rd_mux = ctl_q;
		`RTC_CNT3_ADDR: rd_mux = cnt_q[31:24];
		`RTC_CNT2_ADDR: rd_mux = cnt_q[23:16];
		`RTC_CNT1_ADDR: rd_mux = cnt_q[15:8];
		`RTC_CNT0_ADDR: rd_mux = cnt_q[7:0];
		`RTC_ACC2_ADDR: rd_mux = acc_q[23:16];
		`RTC_ACC1_ADDR: rd_mux = acc_q[15:8];
		`RTC_ACC0_ADDR: rd_mux = acc_q[7:0];
		`RTC_TRIM2_ADDR: rd_mux = trim_q[23:16];
		`RTC_TRIM1_ADDR: rd_mux = trim_q[15:8];
		`RTC_TRIM0_ADDR: rd_mux = trim_q[7:0];
		default: rd_mux = 8'h00;
		endcase
	end

	// software-written copies wait here until the load bit takes effect
	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			cnt_wr_q <= `RTC_CNT_RESET;
			acc_wr_q <= `RTC_ACC_RESET;
			trim_wr_q <= `RTC_TRIM_RESET;
		end else if (CE && SFR_WR) begin
			case (SFR_ADDR)
			`RTC_CNT3_ADDR: cnt_wr_q[31:24] <= SFR_WDATA;
			`RTC_CNT2_ADDR: cnt_wr_q[23:16] <= SFR_WDATA;
			`RTC_CNT1_ADDR: cnt_wr_q[15:8] <= SFR_WDATA;
			`RTC_CNT0_ADDR: cnt_wr_q[7:0] <= SFR_WDATA;
			`RTC_ACC2_ADDR: acc_wr_q[23:16] <= SFR_WDATA;
			`RTC_ACC1_ADDR: acc_wr_q[15:8] <= SFR_WDATA;
			`RTC_ACC0_ADDR: acc_wr_q[7:0] <= SFR_WDATA;
			`RTC_TRIM2_ADDR: trim_wr_q[23:16] <= SFR_WDATA;
			`RTC_TRIM1_ADDR: trim_wr_q[15:8] <= SFR_WDATA;
			`RTC_TRIM0_ADDR: trim_wr_q[7:0] <= SFR_WDATA;
			default: cnt_wr_q <= cnt_wr_q;
			endcase
		end
	end

	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			cnt_q <= `RTC_CNT_RESET;
			acc_q <= `RTC_ACC_RESET;
			trim_q <= `RTC_TRIM_RESET;
			marks_q <= 4'h0;
		end else if (CE) begin
			if (half_mark) begin
				marks_q <= marks_d;
			end
			if (do_load) begin
				cnt_q <= cnt_wr_q;
				acc_q <= acc_wr_q;
				trim_q <= trim_wr_q;
			end else begin
				cnt_q <= cnt_d;
				acc_q <= acc_d;
			end
		end
	end

	// control register: a fresh write of the load bit beats the self-clear
	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			ctl_q <= `RTC_CTL_RESET;
		end else if (CE) begin
			if (wr_ctl) begin
				ctl_q <= {2'b00, SFR_WDATA[5:0]};
			end else if (do_load) begin
				ctl_q[`RTC_CTL_LOAD] <= 1'b0;
			end
		end
	end

	// nothing counts while the flag is clear or the enable is off
	// an ignored flag gets a fresh pulse every half second after the first
	assign wd_expire = (wd_q == HALF_SEC_TICKS[15:0] - 16'h0001) && tick;

	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			POWERDOWN_MUX_CTRL_CTRL <= INT5_RST[`RTC_INT5_POWERDOWN_MUX_CTRL];
			clk_ien_q <= INT5_RST[`RTC_INT5_CLK_IEN];
			clk_flag_q <= INT5_RST[`RTC_INT5_CLK_FLAG];
			link_ien_q <= INT5_RST[`RTC_INT5_LINK_IEN];
			link_flag_q <= INT5_RST[`RTC_INT5_LINK_FLAG];
			keys_ien_q <= INT5_RST[`RTC_INT5_KEYS_IEN];
			keys_flag_q <= INT5_RST[`RTC_INT5_KEYS_FLAG];
		end else if (CE) begin
			if (wr_int5) begin
				POWERDOWN_MUX_CTRL_CTRL <= SFR_WDATA[`RTC_INT5_POWERDOWN_MUX_CTRL];
				clk_ien_q <= SFR_WDATA[`RTC_INT5_CLK_IEN];
				link_ien_q <= SFR_WDATA[`RTC_INT5_LINK_IEN];
				keys_ien_q <= SFR_WDATA[`RTC_INT5_KEYS_IEN];
			end
			// set wins over the read that clears it
			if (int_step) begin
				clk_flag_q <= 1'b1;
			end else if (rd_int5) begin
				clk_flag_q <= 1'b0;
			end
			// link and keys flags: writing 0 clears, event wins over clear
			if (LINK_EVENT) begin
				link_flag_q <= 1'b1;
			end else if (wr_int5 && !SFR_WDATA[`RTC_INT5_LINK_FLAG]) begin
				link_flag_q <= 1'b0;
			end
			if (KEYS_EVENT) begin
				keys_flag_q <= 1'b1;
			end else if (wr_int5 && !SFR_WDATA[`RTC_INT5_KEYS_FLAG]) begin
				keys_flag_q <= 1'b0;
			end
		end
	end

	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			wd_q <= 16'h0000;
			WDT_RESET <= 1'b0;
			INT5_REQ <= 1'b0;
			SFR_RDATA <= 8'h00;
		end else if (CE) begin
			// runs only while armed and the raised flag is not yet serviced
			if (!(clk_ien_q && clk_flag_q) || wd_expire) begin
				wd_q <= 16'h0000;
			end else if (tick) begin
				wd_q <= wd_q + 16'h0001;
			end
			WDT_RESET <= clk_ien_q && clk_flag_q && wd_expire;
			INT5_REQ <= (clk_ien_q && clk_flag_q)
				|| (link_ien_q && link_flag_q)
				|| (keys_ien_q && keys_flag_q);
			if (SFR_RD) begin
				SFR_RDATA <= rd_mux;
			end
		end
	end

endmodule // rtc_block

`default_nettype wire

// ==== hw/rtc_regs.vh ====
// register map, field positions, reset values and timing counts of the clock block
`ifndef RTC_REGS_VH
`define RTC_REGS_VH

`define RTC_ADDR_W 16
`define RTC_INT5_ADDR 16'hFF94
`define RTC_CTL_ADDR 16'hFFB0
`define RTC_CNT3_ADDR 16'hFFB1
`define RTC_CNT2_ADDR 16'hFFB2
`define RTC_CNT1_ADDR 16'hFFB3
`define RTC_CNT0_ADDR 16'hFFB4
`define RTC_ACC2_ADDR 16'hFFB5
`define RTC_ACC1_ADDR 16'hFFB6
`define RTC_ACC0_ADDR 16'hFFB7
`define RTC_TRIM2_ADDR 16'hFFB8
`define RTC_TRIM1_ADDR 16'hFFB9
`define RTC_TRIM0_ADDR 16'hFFBA

`define RTC_INT5_RESET 8'h00
`define RTC_CTL_RESET 8'h00
`define RTC_CNT_RESET 32'h0000_0000
`define RTC_ACC_RESET 24'h00_0000
`define RTC_TRIM_RESET 24'h00_0000

`define RTC_INT5_POWERDOWN_MUX_CTRL 7
`define RTC_INT5_CLK_IEN 5
`define RTC_INT5_CLK_FLAG 4
`define RTC_INT5_LINK_IEN 3
`define RTC_INT5_LINK_FLAG 2
`define RTC_INT5_KEYS_IEN 1
`define RTC_INT5_KEYS_FLAG 0

`define RTC_CTL_LOAD 5
`define RTC_CTL_PER_HI 4
`define RTC_CTL_PER_LO 3
`define RTC_CTL_INT_HI 2
`define RTC_CTL_INT_LO 0

`define RTC_TRIM_SIGN 23

`define RTC_TB_HZ 32768
`define RTC_HALF_SEC_MS 500
`define RTC_MAIN_DIV 2930

`endif

// ==== hw/rtc_timebase.v ====
// time base: synchronised 32 kHz pin or divided main clock, ticks and half-second marks
`timescale 1ns/1ps
`default_nettype none
`include "rtc_regs.vh"

module rtc_timebase #(
	parameter HALF_SEC_TICKS = `RTC_HALF_SEC_MS * `RTC_TB_HZ / 1000,
	parameter MAIN_DIV = `RTC_MAIN_DIV
) (
	input wire mclk,
	input wire rst_n,
	input wire ce,
	input wire osc32k,
	input wire xtal_en,
	output reg tick,
	output reg half_mark
);

	reg osc_s1_q;
	reg osc_s2_q;
	reg osc_s3_q;
	reg xen_s1_q;
	reg xen_s2_q;
	reg [11:0] div_q;
	reg [15:0] half_q;
	wire osc_rise;
	wire div_wrap;
	wire tick_d;

	assign osc_rise = osc_s2_q & ~osc_s3_q;
	assign div_wrap = (div_q == MAIN_DIV[11:0] - 12'h001);
	// without a crystal the main clock divider stands in for the oscillator
	assign tick_d = xen_s2_q ? osc_rise : div_wrap;

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			osc_s1_q <= 1'b0;
			osc_s2_q <= 1'b0;
			osc_s3_q <= 1'b0;
			xen_s1_q <= 1'b0;
			xen_s2_q <= 1'b0;
			div_q <= 12'h000;
			half_q <= 16'h0000;
			tick <= 1'b0;
			half_mark <= 1'b0;
		end else if (ce) begin
			osc_s1_q <= osc32k;
			osc_s2_q <= osc_s1_q;
			osc_s3_q <= osc_s2_q;
			xen_s1_q <= xtal_en;
			xen_s2_q <= xen_s1_q;
			if (div_wrap || xen_s2_q) begin
				div_q <= 12'h000;
			end else begin
				div_q <= div_q + 12'h001;
			end
			tick <= tick_d;
			half_mark <= 1'b0;
			if (tick_d) begin
				if (half_q == HALF_SEC_TICKS[15:0] - 16'h0001) begin
					half_q <= 16'h0000;
					half_mark <= 1'b1;
				end else begin
					half_q <= half_q + 16'h0001;
				end
			end
		end
	end

endmodule // rtc_timebase

`default_nettype wire

// ==== verif/rtc_checker.sv ====
// port assertions for the clock register block
`timescale 1ns/1ps
`default_nettype none
module rtc_checker (
	input wire MCLK,
	input wire RST_N,
	input wire CE,
	input wire [15:0] SFR_ADDR,
	input wire [7:0] SFR_WDATA,
	input wire SFR_WR,
	input wire SFR_RD,
	input wire [7:0] SFR_RDATA,
	input wire LINK_EVENT,
	input wire INT5_REQ,
	input wire WDT_RESET,
	input wire POWERDOWN_MUX_CTRL_CTRL
);
	logic [7:0] en_q;
	logic [4:0] ctl_q;
	wire rd5 = SFR_RD && SFR_ADDR == 16'hFF94;
	wire rdc = SFR_RD && SFR_ADDR == 16'hFFB0;
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	// shadows of the enables and fields that software last wrote
	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			en_q <= 8'h00;
			ctl_q <= 5'h00;
		end else if (SFR_WR && CE) begin
			if (SFR_ADDR == 16'hFF94)
				en_q <= SFR_WDATA & 8'h2A;
			if (SFR_ADDR == 16'hFFB0)
				ctl_q <= SFR_WDATA[4:0];
		end
	end
	a_powerdown_mux_ctrl_follows: assert property (SFR_WR && CE && SFR_ADDR == 16'hFF94
		|=> POWERDOWN_MUX_CTRL_CTRL == $past(SFR_WDATA[7])) else $error("powerdown_mux_ctrl");
	a_int5_unused: assert property (rd5 |=> !SFR_RDATA[6])
		else $error("bit6");
	a_ctl_readback: assert property (rdc |=> SFR_RDATA[7:6] == 2'h0
		&& SFR_RDATA[4:0] == $past(ctl_q)) else $error("ctl read");
	a_req_gated: assert property (INT5_REQ
		|-> ($past(en_q) != 8'h00)) else $error("req ungated");
	a_wdt_one_cycle: assert property (WDT_RESET |=> !WDT_RESET)
		else $error("wdt width");
	a_wdt_armed: assert property (WDT_RESET |-> $past(en_q[5]))
		else $error("wdt unarmed");
	a_link_flag_set: assert property (LINK_EVENT ##1 !SFR_WR ##1 rd5
		|=> SFR_RDATA[2]) else $error("link flag");
	a_unmapped_zero: assert property (SFR_RD && SFR_ADDR < 16'hFF00
		|=> SFR_RDATA == 8'h00) else $error("unmapped");
endmodule // rtc_checker
bind rtc_block rtc_checker u_chk (.MCLK(MCLK), .RST_N(RST_N), .CE(CE),
	.SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR),
	.SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA), .LINK_EVENT(LINK_EVENT),
	.INT5_REQ(INT5_REQ), .WDT_RESET(WDT_RESET), .POWERDOWN_MUX_CTRL_CTRL(POWERDOWN_MUX_CTRL_CTRL));
`default_nettype wire

// ==== verif/tb.sv ====
// self-checking bench for the clock register block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic osc = 1'b0;
	logic xen = 1'b1;
	logic ce = 1'b1;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [1:0] ev = 2'h0;
	logic [15:0] ad = 16'h0000;
	logic [7:0] wd = 8'h00;
	logic [7:0] b, f;
	logic [31:0] c0, c1, s = 32'h38;
	wire [7:0] rdata;
	wire req, wdt, pdm;
	int err_count = 0, num_checks = 0, wdt_n = 0, n;
	always #50 mclk = ~mclk;
	always @(posedge mclk) if (wdt === 1'b1) wdt_n++;
	rtc_block #(.HALF_SEC_TICKS(8)) dut (.MCLK(mclk), .RST_N(rst_n),
		.CE(ce), .OSC32K(osc), .XTAL_EN(xen), .SFR_ADDR(ad),
		.SFR_WDATA(wd), .SFR_WR(wr_s), .SFR_RD(rd_s), .SFR_RDATA(rdata),
		.LINK_EVENT(ev[1]), .KEYS_EVENT(ev[0]), .INT5_REQ(req),
		.WDT_RESET(wdt), .POWERDOWN_MUX_CTRL_CTRL(pdm));
	function logic [31:0] rnd();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// counts per 16 half marks: periods 0..3, trimmed +/-, then intervals
	function int want(input int i);
		return i == 2 ? 16 : i == 3 ? 4 : i == 4 ? 17 : i == 5 ? 15 :
			i == 7 ? 16 : i > 7 ? 16 >> (i - 6) : 8;
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task cy(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		ad <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge mclk);
		wr_s <= 1'b0;
	endtask
	task rd(input logic [15:0] a);
		@(posedge mclk);
		ad <= a;
		rd_s <= 1'b1;
		@(posedge mclk);
		rd_s <= 1'b0;
		cy(1);
		b = rdata;
	endtask
	task rn(input logic [15:0] a, input int k, output logic [31:0] v);
		v = 32'h0;
		for (int i = 0; i < k; i++) begin
			rd(a + 16'(i));
			v = {v[23:0], b};
		end
	endtask
	task tk(input int k);
		repeat (k) begin
			@(posedge mclk);
			osc <= 1'b1;
			repeat (5) @(posedge mclk);
			osc <= 1'b0;
			repeat (5) @(posedge mclk);
		end
	endtask
	task ld(input logic [31:0] c, input logic [23:0] acc, input logic [23:0] trm,
		input logic [7:0] ctl);
		logic [79:0] v;
		v = {c, acc, trm};
		for (int i = 0; i < 10; i++)
			wr(16'hFFB1 + 16'(i), v[79 - 8 * i -: 8]);
		wr(16'hFFB0, ctl | 8'h20);
		rd(16'hFFB0);
		chk(b, ctl | 8'h20);
		tk(1);
		rd(16'hFFB0);
		chk(b, ctl);
		rn(16'hFFB1, 4, c1);
		chk(c1, c);
		rn(16'hFFB5, 3, c1);
		chk(c1, acc);
		rn(16'hFFB8, 3, c1);
		chk(c1, trm);
	endtask
	initial begin
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		rd(16'hFF94);
		chk(b, 8'h00);
		rn(16'hFFB0, 2, c1);
		chk(c1, 32'h0);
		rd(16'h1234);
		chk(b, 8'h00);
		wr(16'hFFB0, 8'hD7);
		rd(16'hFFB0);
		chk(b, 8'h17);
		wr(16'hFF94, 8'hC0);
		cy(1);
		chk(pdm, 1'b1);
		rd(16'hFF94);
		chk(b & 8'hC0, 8'h80);
		$display("registers done");
		for (int p = 0; p < 6; p++) begin
			ld(rnd(), p < 4 ? 24'h0 : 24'hFFFFFF, p < 4 ? 24'h0 : {p == 5, 23'h1},
				p < 4 ? 8'(p << 3) : 8'h10);
			rn(16'hFFB1, 4, c0);
			tk(128);
			rn(16'hFFB1, 4, c1);
			chk(c1 - c0, want(p));
		end
		$display("counting done");
		for (int i = 6; i < 11; i++) begin
			wr(16'hFFB0, 8'(i == 6 ? 3 : i - 3));
			rd(16'hFF94);
			n = 0;
			repeat (16) begin
				tk(8);
				rd(16'hFF94);
				n += b[4];
			end
			chk(n, want(i));
			chk(req, 1'b0);
		end
		$display("intervals done");
		wr(16'hFF94, 8'h20);
		wr(16'hFFB0, 8'h04);
		tk(8);
		cy(1);
		chk(req, 1'b1);
		wdt_n = 0;
		tk(24);
		chk(wdt_n, 3);
		rd(16'hFF94);
		wdt_n = 0;
		repeat (3) begin
			tk(8);
			rd(16'hFF94);
		end
		chk(wdt_n, 0);
		wr(16'hFF94, 8'h00);
		rd(16'hFF94);
		wdt_n = 0;
		tk(24);
		chk(wdt_n, 0);
		$display("watchdog done");
		for (int i = 0; i < 2; i++) begin
			f = i ? 8'h01 : 8'h04;
			wr(16'hFF94, 8'h00);
			@(posedge mclk);
			ev <= i ? 2'h1 : 2'h2;
			@(posedge mclk);
			ev <= 2'h0;
			rd(16'hFF94);
			chk(b & f, f);
			chk(req, 1'b0);
			wr(16'hFF94, f * 3);
			cy(2);
			chk(req, 1'b1);
			wr(16'hFF94, f * 2);
			cy(2);
			chk(req, 1'b0);
		end
		$display("events done");
		@(posedge mclk);
		xen <= 1'b0;
		wr(16'hFFB0, 8'h20);
		cy(2790);
		rd(16'hFFB0);
		chk(b, 8'h20);
		cy(200);
		rd(16'hFFB0);
		chk(b, 8'h00);
		@(posedge mclk);
		ce <= 1'b0;
		wr(16'hFF94, 8'h80);
		cy(1);
		chk(pdm, 1'b0);
		@(posedge mclk);
		ce <= 1'b1;
		$display("divider done");
		end_of_test;
	end
	initial begin
		repeat (100000) @(posedge mclk);
		err_count++;
		end_of_test;
	end
endmodule // tb
`default_nettype wire
